// File: src/tx_soh_pkg.sv
// Constants and types shared by the transmit section-overhead source and trace logic.
package tx_soh_pkg;
    // Register indices; byte address on the bus is four times the index.
    localparam logic [7:0] IDX_NU_DEFAULT = 8'h30;
    localparam logic [7:0] IDX_NU_R1C8 = 8'h31;
    localparam logic [7:0] IDX_NU_R1C9 = 8'h32;
    localparam logic [7:0] IDX_NU_R2C8 = 8'h33;
    localparam logic [7:0] IDX_TRACE_CTRL = 8'h3A;
    localparam logic [7:0] IDX_TRACE_DATA = 8'h3B;
    localparam logic [7:0] IDX_MODE = 8'h40;
    localparam logic [7:0] IDX_NU_SRC = 8'h62;
    localparam logic [7:0] IDX_MEDIA_SRC = 8'h63;
    // Field positions.
    localparam int NU_DEFAULT_EN_BIT = 5;
    localparam int MODE_STM1_BIT = 0;
    localparam int MEDIA_R2C2_BIT = 0;
    localparam int MEDIA_R2C3_BIT = 1;
    localparam int MEDIA_R2C5_BIT = 2;
    localparam int NU_R1C8_LSB = 0;
    localparam int NU_R1C9_LSB = 2;
    localparam int NU_R2C8_LSB = 4;
    localparam int TRACE_ACC_BIT = 1;
    localparam int TRACE_PTR_RST_BIT = 0;
    // Reset values.
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [2:0] MEDIA_SRC_RESET = 3'h0;
    localparam logic [5:0] NU_SRC_RESET = 6'h00;
    localparam logic MODE_STM1_RESET = 1'b1;
    // Source encodings and fixed values.
    localparam logic [1:0] NU_SRC_PROC = 2'h0;
    localparam logic [1:0] NU_SRC_TX_OVERHEAD_INPUT = 2'h1;
    localparam logic [7:0] TRACE_FIXED_BYTE = 8'h01;
    localparam int TRACE_DEPTH = 16;

    // Which overhead byte the transmit framer is emitting this cycle.
    typedef enum logic [2:0] {
        SLOT_OTHER,
        SLOT_R2C2,
        SLOT_R2C3,
        SLOT_R2C5,
        SLOT_R1C8,
        SLOT_R1C9,
        SLOT_R2C8,
        SLOT_TRACE
    } slot_t;
endpackage : tx_soh_pkg

// File: src/trace_string_store.sv
// Storage for the transmit trace string, one byte per pointer location.
`timescale 1ns/1ps
module trace_string_store #(
    parameter int DEPTH = tx_soh_pkg::TRACE_DEPTH,
    parameter int PW = $clog2(DEPTH)
) (
    input wire logic clk_sys, // System clock.
    input wire logic rst_n, // Synchronised active-low reset.
    input wire logic wr_en, // Store wr_byte at addr.
    input wire logic [PW-1:0] addr, // String location.
    input wire logic [7:0] wr_byte, // Byte to store.
    output logic [7:0] rd_byte // Byte at addr, combinational.
);
    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
    } store_t;
    store_t s_q;
    store_t s_d;

    always_comb begin
        s_d = s_q;
        if (wr_en) begin
            s_d.mem[addr] = wr_byte;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_byte = s_q.mem[addr];
endmodule : trace_string_store

// File: src/tx_soh_byte_source_and_trace.sv
// Transmit section-overhead byte source selection, national bytes and trace string.
//
// Overview of operation
// - Bit 2 picks row2 col5 source.
// - Bit 1 picks row2 col3 source.
// - Bit 0 picks row2 col2 source.
// - Media selects act only in STM-1.
// - Access bit clear: insertion advances pointer.
// - Access bit set: processor accesses advance pointer.
// - Processor access sends fixed 01H trace.
// - Pointer reset bit rising edge clears pointer.
// - Trace data register is 8-bit, resets zero.
// - Row1 col8 processor byte when 00, default off.
// - Row1 col9 processor byte when 00, default off.
// - Row2 col8 processor byte when select 00.
// - National select (STM-1 only, else input): 00 processor, 01 input, 1X received.
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
module tx_soh_byte_source_and_trace #(
    parameter int TRACE_DEPTH = tx_soh_pkg::TRACE_DEPTH,
    parameter logic [7:0] NATIONAL_DEFAULT_BYTE = 8'h00
) (
    input wire logic clk_sys, // System clock, 40 MHz.
    input wire logic nrst, // Asynchronous active-low reset.
    input wire logic cyc_i, // Wishbone cycle.
    input wire logic stb_i, // Wishbone strobe.
    input wire logic we_i, // Wishbone write enable.
    input wire logic [9:0] adr_i, // Wishbone byte address.
    input wire logic [3:0] sel_i, // Wishbone byte lanes.
    input wire logic [31:0] dat_i, // Wishbone write data.
    output logic [31:0] dat_o, // Wishbone read data.
    output logic ack_o, // Wishbone acknowledge.
    input wire logic slot_valid, // Framer requests an overhead byte.
    input wire tx_soh_pkg::slot_t slot, // Which overhead byte is requested.
    input wire logic [7:0] tx_overhead_input, // Byte from the transmit overhead input.
    input wire logic [7:0] rx_byte, // Received byte at the same position.
    output logic [7:0] soh_byte, // Selected byte for the framer.
    output logic soh_valid // soh_byte is valid.
);
    localparam int PW = $clog2(TRACE_DEPTH);

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic [7:0] tx_national_r1c8_value;
        logic [7:0] tx_national_r1c9_value;
        logic [7:0] tx_national_r2c8_value;
        logic [2:0] media_sel;
        logic [5:0] nu_sel;
        logic national_default_enable;
        logic stm1;
        logic tx_trace_processor_access;
        logic tx_trace_pointer_reset;
        logic [PW-1:0] ptr;
        logic [7:0] out_byte;
        logic out_valid;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic rst_meta_q;
    logic rst_sync_n;
    logic [7:0] idx;
    logic bus_done;
    logic wr;
    logic data_acc;
    logic mem_we;
    logic [7:0] mem_byte;
    logic [1:0] nsel;

    function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
        if (p == PW'(TRACE_DEPTH - 1)) begin
            return '0;
        end
        return p + PW'(1);
    endfunction : next_ptr

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release synchroniser.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_n <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Trace string storage.
    trace_string_store #(
        .DEPTH(TRACE_DEPTH),
        .PW(PW)
    ) u_store (
        .clk_sys(clk_sys),
        .rst_n(rst_sync_n),
        .wr_en(mem_we),
        .addr(s_q.ptr),
        .wr_byte(dat_i[7:0]),
        .rd_byte(mem_byte)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Register bus, pointer control and byte selection.
    always_comb begin
        s_d = s_q;
        nsel = tx_soh_pkg::NU_SRC_PROC;
        idx = adr_i[9:2];
        // Writes and read side effects land on the edge where ack is seen high.
        bus_done = cyc_i & stb_i & s_q.ack;
        wr = bus_done & we_i & sel_i[0];
        data_acc = bus_done && (idx == tx_soh_pkg::IDX_TRACE_DATA);
        mem_we = wr && (idx == tx_soh_pkg::IDX_TRACE_DATA);
        s_d.ack = cyc_i & stb_i & ~s_q.ack;

        if (cyc_i && stb_i && !s_q.ack) begin
            s_d.dat = 32'h0000_0000;
            case (idx)
                tx_soh_pkg::IDX_NU_DEFAULT: begin
                    s_d.dat[tx_soh_pkg::NU_DEFAULT_EN_BIT] = s_q.national_default_enable;
                end
                tx_soh_pkg::IDX_NU_R1C8: begin
                    s_d.dat[7:0] = s_q.tx_national_r1c8_value;
                end
                tx_soh_pkg::IDX_NU_R1C9: begin
                    s_d.dat[7:0] = s_q.tx_national_r1c9_value;
                end
                tx_soh_pkg::IDX_NU_R2C8: begin
                    s_d.dat[7:0] = s_q.tx_national_r2c8_value;
                end
                tx_soh_pkg::IDX_TRACE_CTRL: begin
                    s_d.dat[tx_soh_pkg::TRACE_ACC_BIT] = s_q.tx_trace_processor_access;
                    s_d.dat[tx_soh_pkg::TRACE_PTR_RST_BIT] = s_q.tx_trace_pointer_reset;
                end
                tx_soh_pkg::IDX_TRACE_DATA: begin
                    s_d.dat[7:0] = mem_byte;
                end
                tx_soh_pkg::IDX_MODE: begin
                    s_d.dat[tx_soh_pkg::MODE_STM1_BIT] = s_q.stm1;
                end
                tx_soh_pkg::IDX_NU_SRC: begin
                    s_d.dat[5:0] = s_q.nu_sel;
                end
                tx_soh_pkg::IDX_MEDIA_SRC: begin
                    s_d.dat[2:0] = s_q.media_sel;
                end
                default: begin
                    s_d.dat = 32'h0000_0000;
                end
            endcase
        end

        if (wr) begin
            case (idx)
                tx_soh_pkg::IDX_NU_DEFAULT: begin
                    s_d.national_default_enable = dat_i[tx_soh_pkg::NU_DEFAULT_EN_BIT];
                end
                tx_soh_pkg::IDX_NU_R1C8: begin
                    s_d.tx_national_r1c8_value = dat_i[7:0];
                end
                tx_soh_pkg::IDX_NU_R1C9: begin
                    s_d.tx_national_r1c9_value = dat_i[7:0];
                end
                tx_soh_pkg::IDX_NU_R2C8: begin
                    s_d.tx_national_r2c8_value = dat_i[7:0];
                end
                tx_soh_pkg::IDX_TRACE_CTRL: begin
                    s_d.tx_trace_processor_access = dat_i[tx_soh_pkg::TRACE_ACC_BIT];
                    s_d.tx_trace_pointer_reset = dat_i[tx_soh_pkg::TRACE_PTR_RST_BIT];
                end
                tx_soh_pkg::IDX_MODE: begin
                    s_d.stm1 = dat_i[tx_soh_pkg::MODE_STM1_BIT];
                end
                tx_soh_pkg::IDX_NU_SRC: begin
                    s_d.nu_sel = dat_i[5:0];
                end
                tx_soh_pkg::IDX_MEDIA_SRC: begin
                    s_d.media_sel = dat_i[2:0];
                end
                default: begin
                    s_d.media_sel = s_q.media_sel;
                end
            endcase
        end

        // Pointer: a reset edge beats any advance in the same cycle.
        if (wr && (idx == tx_soh_pkg::IDX_TRACE_CTRL)
            && dat_i[tx_soh_pkg::TRACE_PTR_RST_BIT] && !s_q.tx_trace_pointer_reset) begin
            s_d.ptr = '0;
        end else if (s_q.tx_trace_processor_access) begin
            if (data_acc) begin
                s_d.ptr = next_ptr(s_q.ptr);
            end
        end else if (slot_valid && (slot == tx_soh_pkg::SLOT_TRACE)) begin
            s_d.ptr = next_ptr(s_q.ptr);
        end

        s_d.out_valid = slot_valid;
        s_d.out_byte = tx_overhead_input;
        if (slot_valid) begin
            case (slot)
                tx_soh_pkg::SLOT_R2C2: begin
                    if (s_q.stm1 && s_q.media_sel[tx_soh_pkg::MEDIA_R2C2_BIT]) begin
                        s_d.out_byte = rx_byte;
                    end
                end
                tx_soh_pkg::SLOT_R2C3: begin
                    if (s_q.stm1 && s_q.media_sel[tx_soh_pkg::MEDIA_R2C3_BIT]) begin
                        s_d.out_byte = rx_byte;
                    end
                end
                tx_soh_pkg::SLOT_R2C5: begin
                    if (s_q.stm1 && s_q.media_sel[tx_soh_pkg::MEDIA_R2C5_BIT]) begin
                        s_d.out_byte = rx_byte;
                    end
                end
                tx_soh_pkg::SLOT_TRACE: begin
                    s_d.out_byte = s_q.tx_trace_processor_access
                        ? tx_soh_pkg::TRACE_FIXED_BYTE : mem_byte;
                end
                tx_soh_pkg::SLOT_R1C8, tx_soh_pkg::SLOT_R1C9, tx_soh_pkg::SLOT_R2C8: begin
                    if (slot == tx_soh_pkg::SLOT_R1C8) begin
                        nsel = s_q.nu_sel[tx_soh_pkg::NU_R1C8_LSB +: 2];
                    end else if (slot == tx_soh_pkg::SLOT_R1C9) begin
                        nsel = s_q.nu_sel[tx_soh_pkg::NU_R1C9_LSB +: 2];
                    end else begin
                        nsel = s_q.nu_sel[tx_soh_pkg::NU_R2C8_LSB +: 2];
                    end
                    if (!s_q.stm1 || nsel == tx_soh_pkg::NU_SRC_TX_OVERHEAD_INPUT) begin
                        s_d.out_byte = tx_overhead_input;
                    end else if (nsel[1]) begin
                        s_d.out_byte = rx_byte;
                    end else if (slot == tx_soh_pkg::SLOT_R2C8) begin
                        s_d.out_byte = s_q.tx_national_r2c8_value;
                    end else if (s_q.national_default_enable) begin
                        s_d.out_byte = NATIONAL_DEFAULT_BYTE;
                    end else if (slot == tx_soh_pkg::SLOT_R1C8) begin
                        s_d.out_byte = s_q.tx_national_r1c8_value;
                    end else begin
                        s_d.out_byte = s_q.tx_national_r1c9_value;
                    end
                end
                default: begin
                    s_d.out_byte = tx_overhead_input;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_q <= '0;
            s_q.stm1 <= tx_soh_pkg::MODE_STM1_RESET;
            s_q.media_sel <= tx_soh_pkg::MEDIA_SRC_RESET;
            s_q.nu_sel <= tx_soh_pkg::NU_SRC_RESET;
            s_q.tx_national_r1c8_value <= tx_soh_pkg::BYTE_RESET;
            s_q.tx_national_r1c9_value <= tx_soh_pkg::BYTE_RESET;
            s_q.tx_national_r2c8_value <= tx_soh_pkg::BYTE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign dat_o = s_q.dat;
    assign ack_o = s_q.ack;
    assign soh_byte = s_q.out_byte;
    assign soh_valid = s_q.out_valid;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_sync_n);

    ack_single_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    ack_after_req_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing one cycle after request");
    media_r2c5_rx_a: assert property (slot_valid && slot == tx_soh_pkg::SLOT_R2C5
        && s_q.stm1 && s_q.media_sel[2] |=> soh_byte == $past(rx_byte))
        else $error("row2 col5 not forwarded from received byte");
    media_r2c3_rx_a: assert property (slot_valid && slot == tx_soh_pkg::SLOT_R2C3
        && s_q.stm1 && s_q.media_sel[1] |=> soh_byte == $past(rx_byte))
        else $error("row2 col3 not forwarded from received byte");
    media_r2c2_rx_a: assert property (slot_valid && slot == tx_soh_pkg::SLOT_R2C2
        && s_q.stm1 && s_q.media_sel[0] |=> soh_byte == $past(rx_byte))
        else $error("row2 col2 not forwarded from received byte");
    media_stm0_tx_overhead_input_a: assert property (slot_valid && !s_q.stm1
        && slot == tx_soh_pkg::SLOT_R2C5 |=> soh_byte == $past(tx_overhead_input))
        else $error("media select acted outside STM-1");
    trace_fixed_byte_a: assert property (slot_valid && slot == tx_soh_pkg::SLOT_TRACE
        && s_q.tx_trace_processor_access |=> soh_valid && soh_byte == 8'h01)
        else $error("fixed trace byte not sent under processor access");
    ptr_reset_edge_a: assert property (wr && idx == tx_soh_pkg::IDX_TRACE_CTRL
        && dat_i[0] && !s_q.tx_trace_pointer_reset |=> s_q.ptr == '0)
        else $error("pointer not cleared on reset bit rising edge");
    ptr_insert_adv_a: assert property (!s_q.tx_trace_processor_access && !wr && slot_valid
        && slot == tx_soh_pkg::SLOT_TRACE |=> s_q.ptr == next_ptr($past(s_q.ptr)))
        else $error("insertion did not advance pointer");
    ptr_cpu_adv_a: assert property (s_q.tx_trace_processor_access && data_acc
        && !wr |=> s_q.ptr == next_ptr($past(s_q.ptr)))
        else $error("processor access did not advance pointer");
    nu_r2c8_cpu_a: assert property (slot_valid && slot == tx_soh_pkg::SLOT_R2C8 && s_q.stm1
        && s_q.nu_sel[5:4] == 2'h0 |=> soh_byte == $past(s_q.tx_national_r2c8_value))
        else $error("row2 col8 processor byte not sent");
    nu_r1c8_cpu_a: assert property (slot_valid && slot == tx_soh_pkg::SLOT_R1C8 && s_q.stm1
        && s_q.nu_sel[1:0] == 2'h0 && !s_q.national_default_enable
        |=> soh_byte == $past(s_q.tx_national_r1c8_value))
        else $error("row1 col8 processor byte not sent");
    nu_r1c9_cpu_a: assert property (slot_valid && slot == tx_soh_pkg::SLOT_R1C9 && s_q.stm1
        && s_q.nu_sel[3:2] == 2'h0 && !s_q.national_default_enable
        |=> soh_byte == $past(s_q.tx_national_r1c9_value))
        else $error("row1 col9 processor byte not sent");
    nu_r2c8_rx_a: assert property (slot_valid && slot == tx_soh_pkg::SLOT_R2C8 && s_q.stm1
        && s_q.nu_sel[5] |=> soh_byte == $past(rx_byte))
        else $error("row2 col8 received byte not forwarded");

    bus_write_c: cover property (wr);
    trace_insert_c: cover property (slot_valid && slot == tx_soh_pkg::SLOT_TRACE);
    ptr_wrap_c: cover property (s_q.ptr == PW'(TRACE_DEPTH - 1) ##1 s_q.ptr == '0);
    national_default_c: cover property (slot_valid && s_q.national_default_enable);
    ptr_reset_c: cover property (wr && idx == tx_soh_pkg::IDX_TRACE_CTRL && dat_i[0]);
endmodule : tx_soh_byte_source_and_trace

// File: dv/tb_tx_soh_byte_source_and_trace.sv
// Self-checking bench for the transmit overhead byte source and trace block.
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
end
module tb_tx_soh_byte_source_and_trace;
    ////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] DEF_BYTE = 8'h3C;
    localparam logic [7:0] OVH = 8'h11;
    localparam logic [7:0] RXB = 8'h22;
    logic clk_sys, nrst, cyc_i, stb_i, we_i, ack_o, slot_valid, soh_valid;
    logic [9:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o;
    tx_soh_pkg::slot_t slot;
    logic [7:0] tx_overhead_input, rx_byte, soh_byte, junk;
    int err_count, num_checks, cycles;

    tx_soh_byte_source_and_trace #(.NATIONAL_DEFAULT_BYTE(DEF_BYTE)) i_dut (
        .clk_sys(clk_sys), .nrst(nrst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .slot_valid(slot_valid), .slot(slot), .tx_overhead_input(tx_overhead_input),
        .rx_byte(rx_byte), .soh_byte(soh_byte), .soh_valid(soh_valid)
    );

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic conclude;
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude

    // The whole run needs a few hundred cycles; the ceiling leaves ample margin.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            $display("[ERR] t=%0t run did not finish", $time);
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data and ack are taken at the edge where ack is sampled high.
    task automatic wb_cycle(input logic [7:0] idx, input logic w, input logic [3:0] sel,
                            input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_sys);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {idx, 2'b00};
        sel_i <= sel;
        dat_i <= {24'h000000, d};
        // Only the run ceiling ends this wait; the slave's latency is not assumed.
        do begin
            @(posedge clk_sys);
        end while (ack_o !== 1'b1);
        q = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask : wb_cycle

    task automatic wb_write(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        wb_cycle(idx, 1'b1, 4'hF, d, q);
    endtask : wb_write

    task automatic wb_read(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] q;
        wb_cycle(idx, 1'b0, 4'hF, 8'h00, q);
        `CHK(q, exp)
    endtask : wb_read

    // One framer request; the answer is looked at in the cycle after it.
    task automatic slot_chk(input tx_soh_pkg::slot_t s, input logic [7:0] exp);
        @(posedge clk_sys);
        slot_valid <= 1'b1;
        slot <= s;
        @(posedge clk_sys);
        slot_valid <= 1'b0;
        @(posedge clk_sys);
        `CHK(soh_valid, 1'b1)
        `CHK(soh_byte, exp)
    endtask : slot_chk

    function automatic logic [7:0] nat_exp(input int c, input logic [7:0] proc);
        return (c == 0) ? proc : ((c == 1) ? OVH : RXB);
    endfunction : nat_exp

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {cyc_i, stb_i, we_i, slot_valid} = 4'h0;
        adr_i = 10'h000;
        sel_i = 4'h0;
        dat_i = 32'h00000000;
        slot = tx_soh_pkg::SLOT_OTHER;
        tx_overhead_input = OVH;
        rx_byte = RXB;
        err_count = 0;
        num_checks = 0;
        cycles = 0;
        nrst = 1'b0;
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        wb_read(tx_soh_pkg::IDX_NU_R1C8, 8'h00);
        wb_read(tx_soh_pkg::IDX_NU_R1C9, 8'h00);
        wb_read(tx_soh_pkg::IDX_NU_R2C8, 8'h00);
        wb_read(tx_soh_pkg::IDX_TRACE_DATA, 8'h00);
        wb_read(tx_soh_pkg::IDX_MEDIA_SRC, 8'h00);
        wb_read(tx_soh_pkg::IDX_MODE, 8'h01);
        wb_read(tx_soh_pkg::IDX_TRACE_CTRL, 8'h00);
        wb_read(8'h7F, 8'h00);
        wb_write(tx_soh_pkg::IDX_NU_R1C8, 8'hA5);
        wb_write(tx_soh_pkg::IDX_NU_R1C9, 8'h5A);
        wb_write(tx_soh_pkg::IDX_NU_R2C8, 8'hC3);
        wb_cycle(tx_soh_pkg::IDX_NU_R1C8, 1'b1, 4'hE, 8'h77, junk);
        wb_read(tx_soh_pkg::IDX_NU_R1C8, 8'hA5);
        wb_read(tx_soh_pkg::IDX_NU_R2C8, 8'hC3);
        for (int c = 0; c < 4; c++) begin
            wb_write(tx_soh_pkg::IDX_NU_SRC, {2'b00, 2'(c), 2'(c), 2'(c)});
            wb_read(tx_soh_pkg::IDX_NU_SRC, {2'b00, 2'(c), 2'(c), 2'(c)});
            slot_chk(tx_soh_pkg::SLOT_R1C8, nat_exp(c, 8'hA5));
            slot_chk(tx_soh_pkg::SLOT_R1C9, nat_exp(c, 8'h5A));
            slot_chk(tx_soh_pkg::SLOT_R2C8, nat_exp(c, 8'hC3));
        end
        // default enable overrides row 1 only.
        wb_write(tx_soh_pkg::IDX_NU_SRC, 8'h00);
        wb_write(tx_soh_pkg::IDX_NU_DEFAULT, 8'h20);
        wb_read(tx_soh_pkg::IDX_NU_DEFAULT, 8'h20);
        slot_chk(tx_soh_pkg::SLOT_R1C8, DEF_BYTE);
        slot_chk(tx_soh_pkg::SLOT_R1C9, DEF_BYTE);
        slot_chk(tx_soh_pkg::SLOT_R2C8, 8'hC3);
        wb_write(tx_soh_pkg::IDX_NU_DEFAULT, 8'h00);
        for (int m = 0; m < 8; m++) begin
            wb_write(tx_soh_pkg::IDX_MEDIA_SRC, 8'(m));
            wb_read(tx_soh_pkg::IDX_MEDIA_SRC, 8'(m));
            slot_chk(tx_soh_pkg::SLOT_R2C2, m[0] ? RXB : OVH);
            slot_chk(tx_soh_pkg::SLOT_R2C3, m[1] ? RXB : OVH);
            slot_chk(tx_soh_pkg::SLOT_R2C5, m[2] ? RXB : OVH);
        end
        // selects have no effect in STM-0.
        wb_write(tx_soh_pkg::IDX_MODE, 8'h00);
        wb_read(tx_soh_pkg::IDX_MODE, 8'h00);
        wb_write(tx_soh_pkg::IDX_NU_SRC, 8'h2A);
        slot_chk(tx_soh_pkg::SLOT_R2C5, OVH);
        slot_chk(tx_soh_pkg::SLOT_R2C2, OVH);
        slot_chk(tx_soh_pkg::SLOT_R1C8, OVH);
        wb_write(tx_soh_pkg::IDX_MODE, 8'h01);
        wb_write(tx_soh_pkg::IDX_MEDIA_SRC, 8'h00);
        wb_write(tx_soh_pkg::IDX_NU_SRC, 8'h00);
        // processor fills and reads the string.
        wb_write(tx_soh_pkg::IDX_TRACE_CTRL, 8'h02);
        wb_write(tx_soh_pkg::IDX_TRACE_CTRL, 8'h03);
        for (int i = 0; i < 16; i++) wb_write(tx_soh_pkg::IDX_TRACE_DATA, 8'(8'h40 + i));
        slot_chk(tx_soh_pkg::SLOT_TRACE, tx_soh_pkg::TRACE_FIXED_BYTE);
        wb_write(tx_soh_pkg::IDX_TRACE_CTRL, 8'h02);
        wb_write(tx_soh_pkg::IDX_TRACE_CTRL, 8'h03);
        for (int i = 0; i < 16; i++) begin
            wb_read(tx_soh_pkg::IDX_TRACE_DATA, 8'(8'h40 + i));
        end
        wb_read(tx_soh_pkg::IDX_TRACE_DATA, 8'h40);
        // A second write of a set reset bit must leave the pointer alone.
        wb_write(tx_soh_pkg::IDX_TRACE_CTRL, 8'h03);
        wb_read(tx_soh_pkg::IDX_TRACE_CTRL, 8'h03);
        wb_read(tx_soh_pkg::IDX_TRACE_DATA, 8'h41);
        // insertion walks the string once access is handed back.
        wb_write(tx_soh_pkg::IDX_TRACE_CTRL, 8'h00);
        wb_write(tx_soh_pkg::IDX_TRACE_CTRL, 8'h01);
        for (int i = 0; i < 16; i++) begin
            slot_chk(tx_soh_pkg::SLOT_TRACE, 8'(8'h40 + i));
        end
        slot_chk(tx_soh_pkg::SLOT_TRACE, 8'h40);
        wb_read(tx_soh_pkg::IDX_TRACE_DATA, 8'h41);
        wb_read(tx_soh_pkg::IDX_TRACE_DATA, 8'h41);
        conclude();
    end
endmodule : tb_tx_soh_byte_source_and_trace
